// ==== rtl/cafr_framer.sv ====
// Acknowledgment message framer: builds answers and decodes received acks
// Function
// - Send an acknowledgment frame for each request that needs one.
// - Destination field of the identifier is the global value 255.
// - Byte 1 control: 0 ack, 1 nack, 2 denied, 3 busy.
// - Supported but security refuses access gives code 2.
// - Supported but too busy to respond gives code 3.
// - Bytes 3 to 5 are always filled with 0xFF.
// - Byte 2 holds the group function value, else 0xFF.
// - Group function value is group specific, usually its first data byte.
// - Bytes 6 to 8 carry the group number, least significant byte first.
// - Nack, denied and busy answers echo the group number the same way.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`default_nettype none

module cafr_framer
  import cafr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Request from the device's own message logic
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [23:0] req_pgn,
  input wire logic [7:0] req_gfv,
  input wire logic req_gfv_valid,
  input wire logic req_supported,
  input wire logic req_denied,
  input wire logic req_busy,
  // Frame to the data link
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [28:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  // Frame from the data link
  input wire logic rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  // Decoded acknowledgment
  output logic ack_valid,
  output logic [1:0] ack_code,
  output logic [7:0] ack_gfv,
  output logic [23:0] ack_pgn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cafr_state_t st;
    logic [63:0] data;
    logic en;
    logic fbusy;
    logic [7:0] sa;
    logic [31:0] rdata;
    logic ackv;
    logic [1:0] acode;
    logic [7:0] agfv;
    logic [23:0] apgn;
    logic [15:0] ntx;
    logic [15:0] nign;
  } cafr_regs_t;

  cafr_regs_t s_q;
  cafr_regs_t s_d;

  logic accept;
  logic rx_is_ack;
  logic rx_good;
  logic [7:0] code;

  // ----------------------------------------------------------------
  // Answer selection
  // ----------------------------------------------------------------
  // A request is taken only while idle, so one frame is in flight at once
  assign req_ready = s_q.en && (s_q.st == ST_IDLE);
  assign accept = req_valid && req_ready;

  // Priority: unsupported first, then security, then busy
  always_comb begin
    if (!req_supported) begin
      code = CODE_NACK;
    end else if (req_denied) begin
      code = CODE_DENIED;
    end else if (req_busy || s_q.fbusy) begin
      code = CODE_BUSY;
    end else begin
      code = CODE_ACK;
    end
  end

  // Received frame qualifies as an acknowledgment only with a legal code
  assign rx_is_ack = (rx_id[ID_PF_LSB +: 8] == ACK_PF) && (rx_dlc == ACK_DLC);
  assign rx_good = rx_valid && rx_is_ack && (rx_data[7:0] <= CODE_BUSY);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ackv = 1'b0;
    s_d.rdata = 32'h0000_0000;
    unique case (s_q.st)
      ST_IDLE: begin
        if (accept) begin
          // Byte 1 sits in the low lane of the data word
          s_d.data[7:0] = code;
          s_d.data[15:8] = req_gfv_valid ? req_gfv : FILL_BYTE;
          s_d.data[23:16] = FILL_BYTE;
          s_d.data[31:24] = FILL_BYTE;
          s_d.data[39:32] = FILL_BYTE;
          s_d.data[47:40] = req_pgn[7:0];
          s_d.data[55:48] = req_pgn[15:8];
          s_d.data[63:56] = req_pgn[23:16];
          s_d.st = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_ready) begin
          s_d.st = ST_IDLE;
          s_d.ntx = s_q.ntx + 16'h0001;
        end
      end
    endcase

    // Decode of received acknowledgments, whichever node's request they answer
    if (rx_good) begin
      s_d.ackv = 1'b1;
      s_d.acode = rx_data[1:0];
      s_d.agfv = rx_data[15:8];
      s_d.apgn = rx_data[63:40];
    end else if (rx_valid && rx_is_ack) begin
      s_d.nign = s_q.nign + 16'h0001;
    end

    // Register writes
    if (reg_wr && reg_addr == REG_CTRL) begin
      s_d.en = reg_wdata[CTRL_EN_BIT];
      s_d.fbusy = reg_wdata[CTRL_FBUSY_BIT];
      s_d.sa = reg_wdata[CTRL_SA_LSB +: 8];
    end else if (reg_wr && reg_addr == REG_COUNT) begin
      // Any write clears both counters
      s_d.ntx = 16'h0000;
      s_d.nign = 16'h0000;
    end

    // Register reads; data stands for the one following cycle only
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: begin
          s_d.rdata[CTRL_EN_BIT] = s_q.en;
          s_d.rdata[CTRL_FBUSY_BIT] = s_q.fbusy;
          s_d.rdata[CTRL_SA_LSB +: 8] = s_q.sa;
        end
        REG_STATUS: begin
          s_d.rdata[0] = (s_q.st == ST_SEND);
        end
        REG_RX_INFO: begin
          s_d.rdata[1:0] = s_q.acode;
          s_d.rdata[15:8] = s_q.agfv;
        end
        REG_RX_PGN: begin
          s_d.rdata[23:0] = s_q.apgn;
        end
        REG_COUNT: begin
          s_d.rdata = {s_q.nign, s_q.ntx};
        end
        default: begin
          s_d.rdata = 32'h0000_0000; // Unmapped reads as zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, en: 1'b1, sa: SA_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Identifier is fixed apart from the source address held in a register
  assign tx_valid = (s_q.st == ST_SEND);
  assign tx_id = {ACK_PRIO, 2'b00, ACK_PF, ACK_PS_GLOBAL, s_q.sa};
  assign tx_dlc = ACK_DLC;
  assign tx_data = s_q.data;
  assign reg_rdata = s_q.rdata;
  assign ack_valid = s_q.ackv;
  assign ack_code = s_q.acode;
  assign ack_gfv = s_q.agfv;
  assign ack_pgn = s_q.apgn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_take;
    req_valid && req_ready;
  endsequence

  sequence s_frame_out;
    tx_valid && tx_dlc == ACK_DLC;
  endsequence

  a_answer_sent: assert property (s_take |=> s_frame_out)
    else $error("request taken but no frame presented");

  a_dest_global: assert property (
      tx_valid |-> tx_id[ID_PS_LSB +: 8] == 8'hFF)
    else $error("destination field not global");

  a_frame_fixed: assert property (
      tx_valid |-> tx_id[ID_PF_LSB +: 8] == 8'hE8
      && tx_id[ID_PRIO_LSB +: 3] == 3'h6 && tx_dlc == 4'h8)
    else $error("frame identity wrong");

  a_deny_code: assert property (
      s_take and (req_supported && req_denied) |=> tx_data[7:0] == 8'h02)
    else $error("denied request not answered with code 2");

  a_busy_code: assert property (
      s_take and (req_supported && !req_denied && req_busy)
      |=> tx_data[7:0] == 8'h03)
    else $error("busy request not answered with code 3");

  a_fill_reserved: assert property (
      tx_valid |-> tx_data[39:16] == 24'hFF_FFFF)
    else $error("reserved bytes not filled");

  a_gfv_fill: assert property (
      s_take ##0 !req_gfv_valid |=> tx_data[15:8] == 8'hFF)
    else $error("missing group function value not 0xFF");

  a_pgn_echo: assert property (
      s_take |=> tx_data[63:40] == $past(req_pgn) [*1] ##1 1'b1)
    else $error("group number not echoed in order");

  // The code is checked in the first frame cycle too, not only while waiting
  a_code_legal: assert property (
      tx_valid |-> tx_data[7:0] <= 8'h03
      && ($stable(tx_data) || $rose(tx_valid)))
    else $error("illegal code or frame changed while waiting");

  a_rx_ignore: assert property (
      rx_valid && rx_data[7:0] > 8'h03 |=> !ack_valid)
    else $error("reserved control code accepted");

  a_rx_decode: assert property (
      rx_good |=> ack_valid && ack_code == $past(rx_data[1:0])
      && ack_pgn == $past(rx_data[63:40]))
    else $error("received acknowledgment decoded wrongly");

  // Answer path: codes 1 and 0, forced busy and the value copy, each on its own
  a_nack_code: assert property (
      s_take and !req_supported |=> tx_data[7:0] == 8'h01)
    else $error("unsupported request not answered with code 1");

  a_ack_code: assert property (
      s_take and (req_supported && !req_denied && !req_busy && !s_q.fbusy)
      |=> tx_data[7:0] == 8'h00)
    else $error("served request not answered with code 0");

  a_busy_force: assert property (
      s_take and (req_supported && !req_denied && s_q.fbusy)
      |=> tx_data[7:0] == 8'h03)
    else $error("forced busy not answered with code 3");

  a_gfv_copy: assert property (
      s_take ##0 req_gfv_valid |=> tx_data[15:8] == $past(req_gfv))
    else $error("group function value not copied");

  // A stalled link must see the same frame until it takes it
  a_frame_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("pending frame dropped or changed");

  a_one_pending: assert property (
      tx_valid |-> !req_ready)
    else $error("request accepted while a frame is pending");

  a_frame_done: assert property (
      tx_valid && tx_ready |=> !tx_valid)
    else $error("frame still pending after the link took it");

  a_rx_gfv: assert property (
      rx_good |=> ack_gfv == $past(rx_data[15:8]))
    else $error("received group function value lost");

endmodule // cafr_framer

`default_nettype wire

// ==== rtl/cafr_pkg.sv ====
// Constants and types shared by the acknowledgment framer
`default_nettype none

package cafr_pkg;

  // ----------------------------------------------------------------
  // Acknowledgment frame identity
  // ----------------------------------------------------------------
  localparam logic [2:0] ACK_PRIO = 3'h6;
  localparam logic [7:0] ACK_PF = 8'hE8;
  localparam logic [7:0] ACK_PS_GLOBAL = 8'hFF;
  localparam logic [17:0] ACK_PGN = 18'h0E800;
  localparam logic [3:0] ACK_DLC = 4'h8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // Control byte codes
  localparam logic [7:0] CODE_ACK = 8'h00;
  localparam logic [7:0] CODE_NACK = 8'h01;
  localparam logic [7:0] CODE_DENIED = 8'h02;
  localparam logic [7:0] CODE_BUSY = 8'h03;

  // Identifier field positions
  localparam int ID_SA_LSB = 0;
  localparam int ID_PS_LSB = 8;
  localparam int ID_PF_LSB = 16;
  localparam int ID_PRIO_LSB = 26;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RX_INFO = 8'h08;
  localparam logic [7:0] REG_RX_PGN = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FBUSY_BIT = 1;
  localparam int CTRL_SA_LSB = 8;
  localparam logic [7:0] SA_RESET = 8'h00;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SEND
  } cafr_state_t;

endpackage

`default_nettype wire

// ==== testbench/cafr_link.sv ====
// Link model: accepts framer output frames after a chosen stall
`default_nettype none

module cafr_link (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [3:0] stall,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q;

  // Count cycles of a pending frame so a slow link can be imitated
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
    end else if (!tx_valid || tx_ready) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end

  assign tx_ready = tx_valid && (wait_q >= stall); // One frame per request
endmodule // cafr_link

`default_nettype wire

// ==== testbench/tb_cafr_framer.sv ====
// Self-checking bench for the acknowledgment framer
`default_nettype none

module tb_cafr_framer;
  import cafr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, reg_wr, reg_rd, req_valid, req_gfv_valid, req_supported;
  logic req_denied, req_busy, req_ready, tx_valid, tx_ready, rx_valid, ack_valid;
  logic [7:0] reg_addr, req_gfv, ack_gfv;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] req_pgn, ack_pgn;
  logic [28:0] tx_id, rx_id;
  logic [3:0] tx_dlc, rx_dlc, stall;
  logic [63:0] tx_data, rx_data;
  logic [1:0] ack_code;
  int error_cnt, check_count, n;

  cafr_framer dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_valid, .req_ready, .req_pgn, .req_gfv, .req_gfv_valid, .req_supported,
    .req_denied, .req_busy, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .rx_valid,
    .rx_id, .rx_dlc, .rx_data, .ack_valid, .ack_code, .ack_gfv, .ack_pgn);
  cafr_link link (.clk, .rst, .tx_valid, .stall, .tx_ready);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A used-up wait counts as a mismatch and closes the run
  task automatic tmo();
    error_cnt++;
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask

  // Flags f = {gfv applies, supported, denied, busy}; c is the expected code
  task automatic req(input logic [23:0] p, input logic [3:0] f, input logic [7:0] c);
    @(posedge clk);
    req_valid <= 1'h1;
    req_pgn <= p;
    req_gfv <= p[7:0] ^ 8'h5A;
    {req_gfv_valid, req_supported, req_denied, req_busy} <= f;
    n = 0;
    do begin @(negedge clk); n++; end while (req_ready !== 1'h1 && n < 50);
    if (n >= 50) tmo();
    @(posedge clk);
    req_valid <= 1'h0;
    #1 chk(tx_valid, 64'h1);
    chk(tx_id, {ACK_PRIO, 2'h0, ACK_PF, ACK_PS_GLOBAL, 8'h3C});
    chk(tx_dlc, ACK_DLC);
    chk(tx_data, {p, 24'hFFFFFF, f[3] ? p[7:0] ^ 8'h5A : FILL_BYTE, c});
    n = 0;
    do begin @(negedge clk); n++; end while (!(tx_valid && tx_ready) && n < 50);
    if (n >= 50) tmo();
    @(posedge clk);
  endtask

  // One received frame; ok says whether a decoded ack must follow
  task automatic rx(input logic [7:0] pf, input logic [7:0] c, input logic ok);
    logic [23:0] p;
    p = 24'hFEF5A1 ^ {16'h0, c};
    @(posedge clk);
    rx_valid <= 1'h1;
    rx_id <= {3'h6, 2'h0, pf, 8'hFF, 8'h21};
    rx_dlc <= 4'h8;
    rx_data <= {p, 24'hFFFFFF, c ^ 8'h0F, c};
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_data <= ~rx_data; // Stale lines do not keep the last value
    #1 chk(ack_valid, ok);
    if (ok) chk({ack_code, ack_gfv, ack_pgn}, {c[1:0], c ^ 8'h0F, p});
  endtask

  // ----------------------------------------------------------------
  // Clock and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'h1;
    {reg_wr, reg_rd, req_valid, req_gfv_valid, req_supported, req_denied} = 6'h0;
    {req_busy, rx_valid, reg_addr, req_gfv, reg_wdata, req_pgn} = 74'h0;
    {rx_id, rx_dlc, rx_data, stall} = 101'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rd(REG_CTRL, 32'h1);
    rd(8'hFC, 32'h0);
    $display("test reset done");
    wr(REG_CTRL, 32'h3C01);
    // Every answer code, link stalling longer each time
    for (int i = 0; i < 4; i++) begin
      stall <= 4'(i * 3);
      req(24'hFEF5A1 + 24'(i), 4'(16'h4D68 >> (i * 4)), 8'((i + 1) % 4));
    end
    wr(REG_CTRL, 32'h3C03);
    req(24'h00EA00, 4'h4, CODE_BUSY);
    wr(REG_CTRL, 32'h3C01);
    req(24'h00EA00, 4'h4, CODE_ACK);
    rd(REG_COUNT, 32'h6);
    $display("test answers done");
    wr(REG_CTRL, 32'h3C00);
    @(posedge clk);
    req_valid <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk({req_ready, tx_valid}, 64'h0);
    req_valid <= 1'h0;
    rd(REG_STATUS, 32'h0);
    $display("test refusal done");
    for (int i = 0; i < 4; i++) rx(ACK_PF, 8'(i), 1'h1);
    rx(ACK_PF, 8'h04, 1'h0);
    rx(ACK_PF, 8'hFF, 1'h0);
    rx(8'hEA, 8'h00, 1'h0);
    rd(REG_COUNT, 32'h00020006);
    wr(REG_COUNT, 32'h0);
    rd(REG_COUNT, 32'h0);
    rd(REG_RX_INFO, 32'h00000C03);
    rd(REG_RX_PGN, 32'h00FEF5A2);
    $display("test receive done");
    // Reset in mid-run brings the enable back and clears the decoded fields
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    rd(REG_CTRL, 32'h1);
    rd(REG_RX_INFO, 32'h0);
    chk(ack_pgn, 64'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule // tb_cafr_framer

`default_nettype wire
